// ---- core/mbp_master.sv ----
// Purpose: Burst master port towards the interconnect fabric.
// Assumes: Fabric and user logic both run on clk; no pin synchronisers.
// Notes:   Read words leave as one-cycle pulses; the user cannot stall them.
//
// Summary of operation
// - Burst length port is 2 to 32 bits.
// - Length one behaves as a single transfer.
// - Longest burst is top bit alone set.
// - Beats may take any number of cycles.
// - Read bursts imply pipelined, no tristate data.
// - One start address per burst only.
// - Finish every beat; no abort, no new address.
// - First accepted edge takes address, length, data.
// - Address, byteenable, length constant through write.
// - N accepted write edges complete the burst.
// - Write low stalls; no capture that edge.
// - Hold write and data while waitrequest high.
// - All byteenables high in every burst.
// - Read address phase ends at waitrequest low.
// - Capture read data each readdatavalid edge.
// - Next command may follow read acceptance directly.
// - Gaps between read words do not end burst.
`timescale 1ns/1ps
`include "mbp_defines.svh"
module mbp_master #(
  parameter int ADDR_W = `MBP_ADDR_W,
  parameter int DATA_W = `MBP_DATA_W,
  parameter int BC_W   = `MBP_BC_W,
  parameter int PEND_W = `MBP_BC_W + `MBP_PEND_XTRA
) (
  input  wire logic              clk,             // Clock, 100 MHz
  input  wire logic              rst_b,           // Sync reset, active low
  // User command port
  input  wire logic              cmdValid,        // Command offered
  output logic                   cmdReady,        // Command taken
  input  wire mbp_pkg::mbp_op_t  cmdOp,           // Read or write
  input  wire logic [ADDR_W-1:0] cmdAddr,         // Start address
  input  wire logic [BC_W-1:0]   cmdLen,          // Beats in burst
  output logic                   cmdErr,          // Illegal length dropped
  // User write data
  input  wire logic              wrValid,         // Write word offered
  output logic                   wrReady,         // Write word taken
  input  wire logic [DATA_W-1:0] wrData,          // Write word
  // User read data
  output logic                   rdValid,         // Read word pulse
  output logic      [DATA_W-1:0] rdData,          // Read word
  output logic                   busy,            // Burst or reads open
  // Fabric side
  output logic      [ADDR_W-1:0] avAddress,       // Start address
  output logic      [BC_W-1:0]   avBurstcount,    // Burst length
  output logic                   avRead,          // Read request
  output logic                   avWrite,         // Write strobe
  output logic      [DATA_W-1:0] avWritedata,     // Write word
  output logic [DATA_W/8-1:0]    avByteenable,    // Byte lanes
  input  wire logic              avWaitrequest,   // Fabric stall
  input  wire logic [DATA_W-1:0] avReaddata,      // Read word
  input  wire logic              avReaddatavalid  // Read word valid
);
  import mbp_pkg::*;

  // Only the top bit set: the longest legal burst
  localparam logic [BC_W-1:0] MAX_LEN = {1'b1, {(BC_W-1){1'b0}}};

  mbp_state_t        state, next_state;
  logic [ADDR_W-1:0] next_address;
  logic [BC_W-1:0]   next_burstcount;
  logic [PEND_W-1:0] pendRd, next_pendRd;
  logic              next_cmdErr;
  logic              next_rdValid;
  logic [DATA_W-1:0] next_rdData;

  logic              rdAcc, wrAcc, cmdTake, lenOk, pendRoom;
  logic              rdWord, wrLoad;
  logic [BC_W-1:0]   beatsLeft;
  logic              beatLast;

  mbp_stream_if #(.W(DATA_W)) inBus ();
  mbp_stream_if #(.W(DATA_W)) outBus ();

  function automatic logic lenLegal(input logic [BC_W-1:0] len);
    lenLegal = (len != '0) && (len <= MAX_LEN);
  endfunction

  // Write words wait here so a fabric stall never drops one
  assign inBus.valid = wrValid;
  assign inBus.data  = wrData;
  assign wrReady     = inBus.ready;

  mbp_fifo2 #(
    .W     (DATA_W),
    .DEPTH (`MBP_FIFO_DEPTH)
  ) u_wbuf (
    .clk   (clk),
    .rst_b (rst_b),
    .fill  (inBus),
    .drain (outBus)
  );

  // Write is dropped while no word is buffered; the burst just pauses
  assign avWrite      = (state == MBP_WBURST) && outBus.valid;
  assign avWritedata  = outBus.data;
  assign wrAcc        = avWrite && !avWaitrequest;
  assign outBus.ready = wrAcc;
  assign rdAcc        = (state == MBP_RADDR) && !avWaitrequest;
  assign avRead       = (state == MBP_RADDR);
  assign avByteenable = '1;

  // Top bit clear leaves room for one more longest burst
  assign pendRoom = !pendRd[PEND_W-1];
  assign cmdReady = ((state == MBP_IDLE) || rdAcc)
                    && (cmdOp == MBP_OP_WRITE || pendRoom);
  assign cmdTake  = cmdValid && cmdReady;
  assign lenOk    = lenLegal(cmdLen);
  assign wrLoad   = cmdTake && lenOk && (cmdOp == MBP_OP_WRITE);
  assign rdWord   = avReaddatavalid && (pendRd != '0);
  assign busy     = (state != MBP_IDLE) || (pendRd != '0);

  mbp_beat_ctr #(
    .W (BC_W)
  ) u_beats (
    .clk     (clk),
    .rst_b   (rst_b),
    .load    (wrLoad),
    .loadVal (cmdLen),
    .dec     (wrAcc),
    .count   (beatsLeft),
    .last    (beatLast)
  );

  // Burst sequencing
  always_comb begin
    next_state      = state;
    next_address    = avAddress;
    next_burstcount = avBurstcount;
    next_cmdErr     = 1'b0;
    case (state)
      MBP_WBURST: begin
        if (wrAcc && beatLast) begin
          next_state = MBP_IDLE;
        end
      end
      MBP_RADDR: begin
        if (rdAcc) begin
          next_state = MBP_IDLE;
        end
      end
      default: begin
        next_state = MBP_IDLE;
      end
    endcase
    // Address and length change only between bursts
    if (cmdTake) begin
      if (lenOk) begin
        next_address    = cmdAddr;
        next_burstcount = cmdLen;
        next_state      = (cmdOp == MBP_OP_READ) ? MBP_RADDR : MBP_WBURST;
      end else begin
        next_cmdErr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state        <= MBP_IDLE;
      avAddress    <= '0;
      avBurstcount <= '0;
      cmdErr       <= 1'b0;
    end else begin
      state        <= next_state;
      avAddress    <= next_address;
      avBurstcount <= next_burstcount;
      cmdErr       <= next_cmdErr;
    end
  end

  // Outstanding read words; gaps in readdatavalid just keep it waiting
  always_comb begin
    next_pendRd  = pendRd;
    next_rdValid = rdWord;
    next_rdData  = rdWord ? avReaddata : rdData;
    if (rdAcc) begin
      next_pendRd = next_pendRd + PEND_W'(avBurstcount);
    end
    if (rdWord) begin
      next_pendRd = next_pendRd - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pendRd  <= '0;
      rdValid <= 1'b0;
      rdData  <= '0;
    end else begin
      pendRd  <= next_pendRd;
      rdValid <= next_rdValid;
      rdData  <= next_rdData;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Own tally of accepted write beats, kept apart from the beat counter
  // so that a fault in that counter cannot hide from the length check
  logic [BC_W-1:0] wrTally, next_wrTally;

  always_comb begin
    next_wrTally = wrTally;
    if (wrLoad) begin
      next_wrTally = '0;
    end else if (wrAcc) begin
      next_wrTally = wrTally + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrTally <= '0;
    end else begin
      wrTally <= next_wrTally;
    end
  end

  sequence sLastBeat;
    wrAcc && beatLast;
  endsequence

  sequence sWrMid;
    (state == MBP_WBURST) && !(wrAcc && beatLast);
  endsequence

  sequence sRdStall;
    avRead && avWaitrequest;
  endsequence

  bcWidth_a: assert property (
    BC_W >= `MBP_BC_W_MIN && BC_W <= `MBP_BC_W_MAX)
    else $error("burst length width out of range");

  rstIdle_a: assert property (disable iff (1'b0)
    !rst_b |=> !avRead && !avWrite && pendRd == '0 && state == MBP_IDLE)
    else $error("reset left a burst open");

  lenLegal_a: assert property ((avRead || avWrite) |->
    avBurstcount != '0 && avBurstcount <= MAX_LEN)
    else $error("illegal burst length presented");

  addrHold_a: assert property (sWrMid |=>
    $stable(avAddress) && $stable(avBurstcount) && !avRead)
    else $error("address or length moved in write burst");

  waitHold_a: assert property ((avWrite && avWaitrequest) |=>
    avWrite && $stable(avWritedata))
    else $error("write word not held under waitrequest");

  lastBeat_a: assert property (sLastBeat |=>
    state == MBP_IDLE && beatsLeft == '0)
    else $error("write burst ran past its length");

  byteAll_a: assert property ((avRead || avWrite) |-> &avByteenable)
    else $error("byte lane low in burst");

  rdHold_a: assert property (sRdStall |=>
    avRead && $stable(avAddress) && $stable(avBurstcount))
    else $error("read request not held under waitrequest");

  rdCapture_a: assert property (rdWord |=>
    rdValid && rdData == $past(avReaddata))
    else $error("read word not captured");

  pendCount_a: assert property ((rdWord && !rdAcc) |=>
    pendRd == $past(pendRd) - 1'b1)
    else $error("outstanding read count off");

  rdNext_a: assert property ((rdAcc && cmdValid && pendRoom)
    |-> cmdReady)
    else $error("command refused at read acceptance");

  wrBeats_a: assert property (wrLoad |=>
    beatsLeft == $past(cmdLen) && state == MBP_WBURST)
    else $error("beat counter not loaded");

  wrStart_a: assert property ((cmdTake && lenOk) |=>
    avAddress == $past(cmdAddr) && avBurstcount == $past(cmdLen))
    else $error("start address or length not presented");

  noAbort_a: assert property ((state == MBP_WBURST) |-> !cmdReady)
    else $error("command taken inside a write burst");

  rdClose_a: assert property ((rdAcc && !cmdTake) |=> !avRead)
    else $error("read address phase not closed");

  gapHold_a: assert property ((!avReaddatavalid && !rdAcc) |=>
    pendRd == $past(pendRd))
    else $error("outstanding read count moved in a gap");

  rdPulse_a: assert property (rdValid |-> $past(rdWord))
    else $error("read word pulse without a fabric word");

  wrCount_a: assert property (sLastBeat |->
    wrTally == avBurstcount - 1'b1)
    else $error("write burst beat count differs from length");
endmodule

// ---- core/mbp_defines.svh ----
// Purpose: Constants of the burst master port.
// Assumes: Included by bare name from the design files.
// Notes:   Widths here are defaults only; modules take them as parameters.
`ifndef MBP_DEFINES_SVH
`define MBP_DEFINES_SVH

`define MBP_ADDR_W    32
`define MBP_DATA_W    32
`define MBP_BC_W      4
`define MBP_BC_W_MIN  2
`define MBP_BC_W_MAX  32
`define MBP_PEND_XTRA 4
`define MBP_FIFO_DEPTH 2

`endif

// ---- core/mbp_pkg.sv ----
// Purpose: Types shared by the burst master port.
// Assumes: Nothing beyond the defines header.
// Notes:   State codes are left to the tools.
package mbp_pkg;
  typedef enum {MBP_IDLE, MBP_WBURST, MBP_RADDR} mbp_state_t;
  typedef enum logic {MBP_OP_WRITE, MBP_OP_READ} mbp_op_t;
endpackage

// ---- core/mbp_stream_if.sv ----
// Purpose: Valid/ready word carrier between the port's modules.
// Assumes: One clock for both ends.
// Notes:   A word moves on an edge with valid and ready both high.
`timescale 1ns/1ps
interface mbp_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- core/mbp_fifo2.sv ----
// Purpose: Two-entry buffer in the write data path.
// Assumes: Synchronous active-low reset.
// Notes:   Full and empty are exact; a push into a full buffer is refused.
`timescale 1ns/1ps
`include "mbp_defines.svh"
module mbp_fifo2 #(
  parameter int W     = `MBP_DATA_W,
  parameter int DEPTH = `MBP_FIFO_DEPTH
) (
  input  wire logic    clk,   // Clock
  input  wire logic    rst_b, // Reset, active low
  mbp_stream_if.snk    fill,  // Filling side
  mbp_stream_if.src    drain  // Draining side
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wrPtr, next_wrPtr;
  logic [PW-1:0] rdPtr, next_rdPtr;
  logic [CW-1:0] count, next_count;
  logic          push, pop;

  assign fill.ready  = (count != CW'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data  = mem[rdPtr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    next_wrPtr = push ? bump(wrPtr) : wrPtr;
    next_rdPtr = pop ? bump(rdPtr) : rdPtr;
    next_count = count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
    if (push) begin
      mem[wrPtr] <= fill.data;
    end
  end
endmodule

// ---- core/mbp_beat_ctr.sv ----
// Purpose: Down counter of beats left in a burst.
// Assumes: Load and decrement never arrive together.
// Notes:   last is high while one beat remains.
`timescale 1ns/1ps
module mbp_beat_ctr #(
  parameter int W = 4
) (
  input  wire logic         clk,     // Clock
  input  wire logic         rst_b,   // Reset, active low
  input  wire logic         load,    // Load at address acceptance
  input  wire logic [W-1:0] loadVal, // Burst length
  input  wire logic         dec,     // Beat accepted
  output logic      [W-1:0] count,   // Beats left
  output logic              last     // One beat left
);
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = loadVal;
    end else if (dec && count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign last = (count == W'(1));
endmodule

// ---- testbench/mbp_fabric_model.sv ----
// Purpose: Fabric model facing the burst master.
// Assumes: One master; slow adds stalls and read gaps.
// Notes:   Read word k of a burst is its address plus k.
`timescale 1ns/1ps
module mbp_fabric_model (
  input  wire logic        clk,   // Clock
  input  wire logic        rst_b, // Reset, active low
  input  wire logic        slow,  // Stall mode
  input  wire logic [31:0] adr,   // Start address
  input  wire logic [3:0]  len,   // Burst length
  input  wire logic        rd,    // Read request
  input  wire logic        wr,    // Write strobe
  input  wire logic [31:0] wdat,  // Write word
  input  wire logic [3:0]  be,    // Byte lanes
  output logic             stall, // Wait request
  output logic      [31:0] rdat,  // Read word
  output logic             rdv,   // Read word valid
  output logic             fault  // Burst fields moved or byte lane low
);
  logic [31:0] wrLog[$];
  logic [31:0] qAdr[$];
  int          qLen[$];
  logic [31:0] wAdr;
  logic [3:0]  wLen;
  int          wLeft;
  int          beat;
  logic        tick;
  // Only one master is served, so the slave stays locked to it
  always @(posedge clk) begin
    if (!rst_b) begin
      {stall, rdv, fault, tick} <= 4'h0;
      rdat <= 32'h0;
      wrLog.delete();
      qAdr.delete();
      qLen.delete();
      wLeft = 0;
      beat = 0;
    end else begin
      tick <= ~tick;
      stall <= slow & ~tick;
      if ((wr || rd) && be !== 4'hf) fault <= 1'b1;
      if (wr && !stall) begin
        if (wLeft == 0) begin
          wAdr = adr;
          wLen = len;
          wLeft = len;
        end
        if (adr !== wAdr || len !== wLen) fault <= 1'b1;
        wLeft--;
        wrLog.push_back(wdat);
      end
      if (rd && !stall) begin
        qAdr.push_back(adr);
        qLen.push_back(len);
      end
      if (qLen.size() > 0 && !(slow && tick)) begin
        rdv <= 1'b1;
        rdat <= qAdr[0] + beat;
        beat++;
        if (beat == qLen[0]) begin
          void'(qAdr.pop_front());
          void'(qLen.pop_front());
          beat = 0;
        end
      end else begin
        rdv <= 1'b0;
        rdat <= ~rdat; // No stale word between beats
      end
    end
  end
endmodule

// ---- testbench/mbp_master_test.sv ----
// Purpose: Self-checking bench of the burst master port.
// Assumes: Default widths; fabric model on the far side.
// Notes:   Inputs change at the falling edge only.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    nChecks++; \
    if ((g) !== (e)) begin \
      numErrors++; \
      $display("ERROR %s exp %h seen %h", nm, e, g); \
    end \
  end
module mbp_master_test;
  import mbp_pkg::*;
  logic        clk, rst_b, slow, cmdValid, cmdReady, cmdErr, wrValid;
  logic        wrReady, rdValid, busy, avRead, avWrite, fault;
  logic        avWaitrequest, avReaddatavalid;
  mbp_op_t     cmdOp;
  logic [31:0] cmdAddr, wrData, rdData, avAddress, avWritedata;
  logic [31:0] avReaddata;
  logic [3:0]  cmdLen, avBurstcount, avByteenable;
  int          numErrors, nChecks;
  int          cyc = 0;

  mbp_master u_mbp_master (
    .clk, .rst_b, .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdLen,
    .cmdErr, .wrValid, .wrReady, .wrData, .rdValid, .rdData, .busy,
    .avAddress, .avBurstcount, .avRead, .avWrite, .avWritedata,
    .avByteenable, .avWaitrequest, .avReaddata, .avReaddatavalid
  );
  mbp_fabric_model u_mbp_fabric_model (
    .clk, .rst_b, .slow, .adr(avAddress), .len(avBurstcount),
    .rd(avRead), .wr(avWrite), .wdat(avWritedata), .be(avByteenable),
    .stall(avWaitrequest), .rdat(avReaddata), .rdv(avReaddatavalid),
    .fault
  );

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      numErrors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [31:0] wd(input logic [31:0] a, input int i);
    return a + i * 32'h0001_0001;
  endfunction

  task automatic cmd(input mbp_op_t op, input logic [31:0] a,
                     input logic [3:0] n);
    cmdOp = op;
    cmdAddr = a;
    cmdLen = n;
    cmdValid = 1'b1;
    while (!cmdReady) @(negedge clk);
    @(negedge clk);
    cmdValid = 1'b0;
  endtask

  task automatic waitIdle();
    int i;
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
    `CHK("busy", 1'b0, busy)
    `CHK("extra", 0, u_mbp_fabric_model.qLen.size())
    `CHK("fault", 1'b0, fault)
  endtask

  task automatic rdCollect(input logic [31:0] a, input int n);
    int i;
    int k;
    for (i = 0; i < n; i++) begin
      for (k = 0; k < 60 && rdValid !== 1'b1; k++) @(negedge clk);
      `CHK("rdData", a + i, rdData)
      @(negedge clk);
    end
  endtask

  task automatic t_write(input logic [31:0] a, input int n, input logic s);
    int i;
    slow = s;
    for (i = 0; i < n; i++) begin
      if (i == 2) begin
        wrValid = 1'b0;
        `CHK("wrReady", 1'b0, wrReady)
        cmd(MBP_OP_WRITE, a, n[3:0]);
      end
      wrValid = 1'b1;
      wrData = wd(a, i);
      while (!wrReady) @(negedge clk);
      @(negedge clk);
      // Gap in wrValid mid-burst; the buffer still holds a word, so avWrite stays up
      if (s) begin
        wrValid = 1'b0;
        @(negedge clk);
      end
    end
    wrValid = 1'b0;
    if (n < 3) cmd(MBP_OP_WRITE, a, n[3:0]);
    waitIdle();
    `CHK("beats", n, u_mbp_fabric_model.wrLog.size())
    `CHK("start address", a, u_mbp_fabric_model.wAdr)
    `CHK("length", n[3:0], u_mbp_fabric_model.wLen)
    for (i = 0; i < n; i++) begin
      `CHK("wdata", wd(a, i), u_mbp_fabric_model.wrLog[i])
    end
    u_mbp_fabric_model.wrLog.delete();
    $display("test write %0d done", n);
  endtask

  task automatic t_read(input logic [31:0] a, input int n, input logic s);
    slow = s;
    cmd(MBP_OP_READ, a, n[3:0]);
    `CHK("avBurstcount", n[3:0], avBurstcount)
    rdCollect(a, n);
    waitIdle();
    $display("test read %0d done", n);
  endtask

  task automatic t_b2b();
    slow = 1'b0;
    cmdOp = MBP_OP_READ;
    cmdAddr = 32'h0000_4000;
    cmdLen = 4'h3;
    cmdValid = 1'b1;
    while (!cmdReady) @(negedge clk);
    @(negedge clk);
    cmdAddr = 32'h0000_5000;
    cmdLen = 4'h2;
    `CHK("cmdReady", 1'b1, cmdReady & avRead & ~avWaitrequest)
    @(negedge clk);
    cmdValid = 1'b0;
    rdCollect(32'h0000_4000, 3);
    rdCollect(32'h0000_5000, 2);
    waitIdle();
    $display("test back to back done");
  endtask

  task automatic t_badLen();
    int i;
    for (i = 0; i < 4; i++) begin
      cmd(mbp_op_t'(i[0]), 32'h0000_6000, i[1] ? 4'h9 : 4'h0);
      `CHK("cmdErr", 1'b1, cmdErr)
      `CHK("no burst", 1'b0, avRead | busy)
      @(negedge clk);
      `CHK("cmdErr", 1'b0, cmdErr)
    end
    $display("test bad length done");
  endtask

  task automatic t_reset();
    slow = 1'b1;
    cmd(MBP_OP_READ, 32'h0000_7000, 4'h8);
    repeat (3) @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("avRead", 1'b0, avRead)
    `CHK("busy", 1'b0, busy)
    `CHK("rdValid", 1'b0, rdValid)
    rst_b = 1'b1;
    @(negedge clk);
    t_read(32'h0000_7100, 2, 1'b0);
    $display("test reset done");
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    slow = 1'b0;
    cmdValid = 1'b0;
    cmdOp = MBP_OP_WRITE;
    cmdAddr = 32'h0;
    cmdLen = 4'h0;
    wrValid = 1'b0;
    wrData = 32'h0;
    numErrors = 0;
    nChecks = 0;
    repeat (16) @(negedge clk);
    `CHK("avWrite", 1'b0, avWrite)
    `CHK("wrReady", 1'b1, wrReady)
    rst_b = 1'b1;
    @(negedge clk);
    t_write(32'h0000_1000, 1, 1'b0);
    t_write(32'h0000_2000, 4, 1'b1);
    t_write(32'h0000_3000, 8, 1'b1);
    t_read(32'h0000_1100, 1, 1'b0);
    t_read(32'h0000_2100, 4, 1'b1);
    t_read(32'h0000_3100, 8, 1'b0);
    t_b2b();
    t_badLen();
    t_reset();
    tally_and_finish();
  end
endmodule
